// ---- test_usb_device_command_decoder.sv ----
`timescale 1ns/1ps
module test_usb_device_command_decoder;
  localparam logic [7:0] EXEC [12] = '{8'h40, 8'h41, 8'h42, 8'h4f, 8'h80, 8'h81,
    8'h8f, 8'h61, 8'h70, 8'h72, 8'h7f, 8'hf4};
  localparam logic [7:0] BAD [8] = '{8'h00, 8'h11, 8'h60, 8'h71, 8'h20, 8'h62, 8'h02, 8'hc0};
  localparam logic [7:0] RDW [7] = '{8'h50, 8'h51, 8'h5f, 8'ha0, 8'haf, 8'hd0, 8'hd3};
  logic        i_clk;
  logic        i_rst_n;
  logic        i_cmd_valid;
  logic [7:0]  i_cmd_code;
  logic [10:0] i_cmd_bytes;
  logic        i_wr_valid;
  logic [15:0] i_wr_data;
  logic        o_cmd_ready, o_cmd_done, o_cmd_refused, o_wr_ready, o_rd_valid, o_rd_last;
  logic        o_cs_n, o_cmd_sel, o_wr_n, o_rd_n, o_data_oe;
  logic [15:0] o_rd_data, o_data_out, dev_data, bus;
  int          miscompares;
  int          comparisons;
  logic [15:0] rw[$];
  logic        rf;
  int          lp;
  assign bus = o_data_oe ? o_data_out : dev_data;
  usb_device_command_decoder #(.EP_ISO_MASK(16'h0008)) DUT (.i_clk, .i_rst_n, .i_cmd_valid,
    .i_cmd_code, .i_cmd_bytes, .o_cmd_ready, .o_cmd_done, .o_cmd_refused, .i_wr_valid,
    .o_wr_ready, .i_wr_data, .o_rd_valid, .o_rd_data, .o_rd_last, .o_cs_n,
    .o_command_select_address_bit(o_cmd_sel), .o_wr_n, .o_rd_n, .o_data_out, .o_data_oe,
    .i_data_in(bus));
  usb_dev_model dev (.i_clk, .i_cs_n(o_cs_n), .i_cmd_sel(o_cmd_sel), .i_wr_n(o_wr_n),
    .i_rd_n(o_rd_n), .i_data(bus), .o_data(dev_data));
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [10:0] n);
    int k;
    rw.delete();
    lp = 0;
    k = 0;
    i_cmd_valid <= 1'b1;
    i_cmd_code <= c;
    i_cmd_bytes <= n;
    do @(posedge i_clk); while (o_cmd_ready !== 1'b1 && ++k < 50);
    i_cmd_valid <= 1'b0;
    chk("take wait", 16'h0000, 16'(k >= 50));
    rf = 1'b0;
    k = 0;
    do
    begin
      @(posedge i_clk);
      if (o_rd_valid === 1'b1)
      begin
        rw.push_back(o_rd_data);
        if (o_rd_last === 1'b1)
          lp = rw.size();
      end
      rf = (o_cmd_refused === 1'b1);
    end while (o_cmd_done !== 1'b1 && !rf && ++k < 2000);
    chk("done wait", 16'h0000, 16'(k >= 2000));
  endtask
  // Valid stays up across the words so no signal is driven twice in a step
  task automatic fill(input logic [15:0] base, input int n);
    i_wr_valid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      i_wr_data <= base + 16'(i);
      @(posedge i_clk);
    end
    i_wr_valid <= 1'b0;
  endtask
  task automatic t_exec;
    foreach (EXEC[i])
    begin
      cmd(EXEC[i], 11'h000);
      chk("refused", 16'h0000, 16'(rf));
      chk("code", {8'h00, EXEC[i]}, {8'h00, dev.code_reg});
      chk("words", 16'h0000, 16'(rw.size()));
    end
    $display("exec test done");
  endtask
  task automatic t_refuse;
    int s;
    s = dev.strobes;
    foreach (BAD[i])
    begin
      cmd(BAD[i], 11'h001);
      chk("refused", 16'h0001, 16'(rf));
    end
    cmd(8'h10, 11'h041);
    chk("long read", 16'h0001, 16'(rf));
    cmd(8'h12, 11'h041);
    chk("long read", 16'h0001, 16'(rf));
    chk("strobes", 16'(s), 16'(dev.strobes));
    $display("refuse test done");
  endtask
  task automatic t_word_read;
    foreach (RDW[i])
    begin
      cmd(RDW[i], 11'h000);
      chk("rd count", 16'h0001, 16'(rw.size()));
      chk("rd word", {8'h00, RDW[i]}, rw[0]);
      chk("rd last", 16'h0001, 16'(lp));
    end
    $display("word read test done");
  endtask
  task automatic t_buf_read;
    cmd(8'h10, 11'h003);
    chk("rd count", 16'h0002, 16'(rw.size()));
    chk("rd word", 16'h4010, rw[0]);
    chk("rd odd", 16'h0010, rw[1]);
    chk("rd last", 16'h0002, 16'(lp));
    cmd(8'h12, 11'h040);
    chk("rd count", 16'h0020, 16'(rw.size()));
    for (int k = 0; k < 32; k++)
      chk("rd word", {8'(8'h40 + k), 8'h12}, rw[k]);
    chk("rd last", 16'h0020, 16'(lp));
    cmd(8'h13, 11'h041);
    chk("iso count", 16'h0021, 16'(rw.size()));
    chk("iso odd", 16'h0013, rw[32]);
    cmd(8'h13, 11'h400);
    chk("iso long", 16'h0001, 16'(rf));
    $display("buffer read test done");
  endtask
  task automatic t_write;
    fill(16'h1100, 9);
    chk("full", 16'h0000, 16'(o_wr_ready));
    dev.wq.delete();
    cmd(8'h01, 11'h010);
    chk("wr count", 16'h0008, 16'(dev.wq.size()));
    for (int k = 0; k < 8; k++)
      chk("wr word", 16'h1100 + 16'(k), dev.wq[k]);
    chk("drained", 16'h0001, 16'(o_wr_ready));
    dev.wq.delete();
    fill(16'h2200, 3);
    cmd(8'h01, 11'h003);
    cmd(8'hb0, 11'h000);
    chk("wr count", 16'h0003, 16'(dev.wq.size()));
    for (int k = 0; k < 3; k++)
      chk("wr word", 16'h2200 + 16'(k), dev.wq[k]);
    $display("write test done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #5000000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    i_rst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd_code = 8'h00;
    i_cmd_bytes = 11'h000;
    i_wr_valid = 1'b0;
    i_wr_data = 16'h0000;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    t_exec;
    t_refuse;
    t_word_read;
    t_buf_read;
    t_write;
    end_of_test;
  end
endmodule

// ---- usb_cmd_pkg.sv ----
package usb_cmd_pkg;

  typedef enum logic [2:0] {
    K_BAD     = 3'b000,
    K_EXEC    = 3'b001,
    K_WR_BUF  = 3'b010,
    K_RD_BUF  = 3'b011,
    K_RD_WORD = 3'b100,
    K_WR_WORD = 3'b101
  } kind_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_CMD    = 3'b001,
    S_GAP    = 3'b010,
    S_WR_STB = 3'b011,
    S_RD_STB = 3'b100
  } state_t;

endpackage

// ---- usb_cmd_props.sv ----
`timescale 1ns/1ps
module usb_cmd_props (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_cmd_valid,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        o_cmd_ready,
  input wire logic        o_cmd_done,
  input wire logic        o_cmd_refused,
  input wire logic        o_rd_valid,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_last,
  input wire logic        o_cs_n,
  input wire logic        o_command_select_address_bit,
  input wire logic        o_wr_n,
  input wire logic        o_rd_n,
  input wire logic [15:0] o_data_out,
  input wire logic        o_data_oe
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence
  sequence s_code_out;
    !o_cs_n && o_command_select_address_bit && !o_wr_n;
  endsequence
  a_exec_done: assert property (s_take ##0 (i_cmd_code[7:4] inside {4'h4, 4'h8})
    |-> ##1 (s_code_out ##0 (o_data_out[7:0] == $past(i_cmd_code))) ##5 o_cmd_done)
    else $error("no-data command timing wrong");
  a_refuse_quiet: assert property (s_take ##0
    (i_cmd_code inside {8'h00, 8'h11, 8'h60, 8'h71}) |-> ##1 (o_cmd_refused && o_cs_n) ##1 o_cs_n)
    else $error("illegal code not refused");
  a_word_read: assert property (s_take ##0 (i_cmd_code[7:4] inside {4'h5, 4'ha, 4'hd})
    |-> ##6 (!o_rd_n && !o_command_select_address_bit) ##3
    (o_rd_valid && o_rd_last && o_rd_data[15:8] == 8'h00) ##2 o_cmd_done)
    else $error("one-word read wrong");
  a_strobe_cs: assert property ((!o_wr_n || !o_rd_n) |-> !o_cs_n)
    else $error("strobe without select");
  a_oe_write: assert property (o_data_oe |-> !o_wr_n && o_rd_n)
    else $error("bus driven outside write");
  a_read_data: assert property (!o_rd_n |-> !o_command_select_address_bit)
    else $error("read in command phase");
  a_strobe_len: assert property ($fell(o_cs_n) |-> !o_cs_n [*3] ##1 o_cs_n)
    else $error("strobe length wrong");
  a_last_valid: assert property (o_rd_last |-> o_rd_valid ##2 o_cmd_done)
    else $error("last word not followed by done");
endmodule
bind usb_device_command_decoder usb_cmd_props u_props (.i_clk, .i_rst_n, .i_cmd_valid,
  .i_cmd_code, .o_cmd_ready, .o_cmd_done, .o_cmd_refused, .o_rd_valid, .o_rd_data,
  .o_rd_last, .o_cs_n, .o_command_select_address_bit, .o_wr_n, .o_rd_n, .o_data_out,
  .o_data_oe);

// ---- usb_cmd_regs.svh ----
`ifndef USB_CMD_REGS_SVH
`define USB_CMD_REGS_SVH

// Command groups, upper nibble of the command code
`define GRP_WR_BUF    4'h0
`define GRP_RD_BUF    4'h1
`define GRP_STALL     4'h4
`define GRP_STATUS    4'h5
`define GRP_VALIDATE  4'h6
`define GRP_CLEAR     4'h7
`define GRP_UNSTALL   4'h8
`define GRP_ERR_CODE  4'ha
`define GRP_COPY      4'hd

// Endpoint index, lower nibble of the command code
`define EP_CTL_OUT    4'h0
`define EP_CTL_IN     4'h1

// Single codes
`define CMD_ACK_SETUP 8'hf4
`define CMD_UNLOCK    8'hb0

// Transfer limits in bytes
`define MAX_BULK_BYTES 11'h040
`define MAX_ISO_BYTES  11'h3ff

// Bus timing
`define CLK_PERIOD_NS 100
`define T_STROBE_NS   300
`define T_RECOV_NS    200

`endif

// ---- usb_dev_model.sv ----
`timescale 1ns/1ps
module usb_dev_model (
  input  wire logic        i_clk,
  input  wire logic        i_cs_n,
  input  wire logic        i_cmd_sel,
  input  wire logic        i_wr_n,
  input  wire logic        i_rd_n,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_data
);
  logic [7:0]  code_reg = 8'h00;
  logic [7:0]  idx_reg  = 8'h00;
  logic        wr_q     = 1'b1;
  logic        rd_q     = 1'b1;
  logic [15:0] word;
  int          strobes  = 0;
  logic [15:0] wq[$];
  // Upper byte is junk on purpose, so the host must really drop it
  assign word = {8'h40 + idx_reg, code_reg};
  // Released bus shows the inverse, never the last word
  assign o_data = (!i_cs_n && !i_rd_n) ? word : ~word;
  always @(posedge i_clk)
  begin
    wr_q <= i_wr_n;
    rd_q <= i_rd_n;
    if (!i_cs_n && !i_wr_n && wr_q)
    begin
      strobes++;
      if (i_cmd_sel)
      begin
        code_reg <= i_data[7:0];
        idx_reg <= 8'h00;
      end
      else
        wq.push_back(i_data);
    end
    if (!i_cs_n && !i_rd_n && rd_q)
      strobes++;
    if (i_rd_n && !rd_q)
      idx_reg <= idx_reg + 8'h01;
  end
endmodule

// ---- usb_device_command_decoder.sv ----
`timescale 1ns/1ps
`include "usb_cmd_regs.svh"

module cmd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      count_next;

  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      o_in_ready <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg  <= count_next;
      // Registered from the next count, so ready still tracks fill level exactly
      o_in_ready <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule

module usb_device_command_decoder
  import usb_cmd_pkg::*;
#(
  parameter logic [15:0] EP_IN_MASK  = 16'h0002,
  parameter logic [15:0] EP_ISO_MASK = 16'h0000,
  parameter int          FIFO_DEPTH  = 8
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [10:0] i_cmd_bytes,
  output logic             o_cmd_ready,
  output logic             o_cmd_done,
  output logic             o_cmd_refused,
  input  wire logic        i_wr_valid,
  output logic             o_wr_ready,
  input  wire logic [15:0] i_wr_data,
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_data,
  output logic             o_rd_last,
  output logic             o_cs_n,
  output logic             o_command_select_address_bit,
  output logic             o_wr_n,
  output logic             o_rd_n,
  output logic [15:0]      o_data_out,
  output logic             o_data_oe,
  input  wire logic [15:0] i_data_in
);
  localparam int STB_CYC = (`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int REC_CYC = (`T_RECOV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [3:0] STB_LAST = 4'(STB_CYC - 1);
  localparam logic [3:0] REC_LAST = 4'(REC_CYC - 1);

  state_t      state_reg;
  kind_t       kind_reg;
  logic [3:0]  tmr_reg;
  logic [9:0]  left_reg;
  logic        odd_reg;
  logic [15:0] din_meta_reg;
  logic [15:0] din_sync_reg;
  logic        f_valid;
  logic [15:0] f_data;
  logic        f_pop;
  logic        is_write;
  logic        gap_end;
  kind_t       kind_next;

  function automatic kind_t classify(input logic [7:0] c, input logic [10:0] n);
    logic [3:0]  e;
    logic        in_ep;
    logic [10:0] lim;
    e     = c[3:0];
    in_ep = EP_IN_MASK[e];
    lim   = (EP_ISO_MASK[e] && e > `EP_CTL_IN) ? `MAX_ISO_BYTES : `MAX_BULK_BYTES;
    classify = K_BAD;
    case (c[7:4])
      `GRP_WR_BUF: if (e != `EP_CTL_OUT && in_ep && n <= lim) classify = K_WR_BUF;
      `GRP_RD_BUF: if (e != `EP_CTL_IN && !in_ep && n <= lim) classify = K_RD_BUF;
      `GRP_STALL, `GRP_UNSTALL: classify = K_EXEC;
      `GRP_STATUS, `GRP_COPY, `GRP_ERR_CODE: classify = K_RD_WORD;
      `GRP_VALIDATE: if (e != `EP_CTL_OUT && in_ep) classify = K_EXEC;
      `GRP_CLEAR: if (e != `EP_CTL_IN && !in_ep) classify = K_EXEC;
      default:
      begin
        if (c == `CMD_ACK_SETUP) classify = K_EXEC;
        else if (c == `CMD_UNLOCK) classify = K_WR_WORD;
      end
    endcase
  endfunction

  assign kind_next = classify(i_cmd_code, i_cmd_bytes);
  assign is_write  = (kind_reg == K_WR_BUF) || (kind_reg == K_WR_WORD);
  assign gap_end   = (state_reg == S_GAP) && (tmr_reg == '0);
  // Writer stalls here until the source supplies a word
  assign f_pop     = gap_end && (left_reg != '0) && is_write && f_valid;

  cmd_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (o_wr_ready),
    .i_in_data   (i_wr_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_data)
  );

  // Data pins come from another device; synchronise before use
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      din_meta_reg <= 16'h0000;
      din_sync_reg <= 16'h0000;
    end
    else
    begin
      din_meta_reg <= i_data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // Sequencer and bus pins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg                    <= S_IDLE;
      kind_reg                     <= K_BAD;
      tmr_reg                      <= 4'h0;
      left_reg                     <= 10'h000;
      odd_reg                      <= 1'b0;
      o_cmd_ready                  <= 1'b0;
      o_cmd_done                   <= 1'b0;
      o_cmd_refused                <= 1'b0;
      o_cs_n                       <= 1'b1;
      o_command_select_address_bit <= 1'b0;
      o_wr_n                       <= 1'b1;
      o_rd_n                       <= 1'b1;
      o_data_out                   <= 16'h0000;
      o_data_oe                    <= 1'b0;
    end
    else
    begin
      o_cmd_done    <= 1'b0;
      o_cmd_refused <= 1'b0;
      unique case (state_reg)
        S_IDLE:
        begin
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready)
          begin
            o_cmd_ready <= 1'b0;
            // Illegal or unknown codes never reach the device
            if (kind_next == K_BAD)
              o_cmd_refused <= 1'b1;
            else
            begin
              kind_reg <= kind_next;
              odd_reg  <= i_cmd_bytes[0];
              if (kind_next == K_WR_BUF || kind_next == K_RD_BUF)
                left_reg <= 10'((i_cmd_bytes + 11'h001) >> 1);
              else if (kind_next == K_EXEC)
                left_reg <= 10'h000;
              else
                left_reg <= 10'h001;
              o_cs_n                       <= 1'b0;
              o_command_select_address_bit <= 1'b1;
              o_data_out                   <= {8'h00, i_cmd_code};
              o_data_oe                    <= 1'b1;
              o_wr_n                       <= 1'b0;
              tmr_reg                      <= STB_LAST;
              state_reg                    <= S_CMD;
            end
          end
        end
        S_CMD, S_WR_STB:
        begin
          if (tmr_reg == '0)
          begin
            o_wr_n    <= 1'b1;
            o_cs_n    <= 1'b1;
            o_data_oe <= 1'b0;
            if (state_reg == S_WR_STB)
              left_reg <= left_reg - 10'h001;
            tmr_reg   <= REC_LAST;
            state_reg <= S_GAP;
          end
          else
            tmr_reg <= tmr_reg - 4'h1;
        end
        S_GAP:
        begin
          if (tmr_reg != '0)
            tmr_reg <= tmr_reg - 4'h1;
          else if (left_reg == '0)
          begin
            o_cmd_done  <= 1'b1;
            o_cmd_ready <= 1'b1;
            state_reg   <= S_IDLE;
          end
          else if (is_write)
          begin
            if (f_valid)
            begin
              o_cs_n                       <= 1'b0;
              o_command_select_address_bit <= 1'b0;
              o_data_out                   <= f_data;
              o_data_oe                    <= 1'b1;
              o_wr_n                       <= 1'b0;
              tmr_reg                      <= STB_LAST;
              state_reg                    <= S_WR_STB;
            end
          end
          else
          begin
            o_cs_n                       <= 1'b0;
            o_command_select_address_bit <= 1'b0;
            o_rd_n                       <= 1'b0;
            tmr_reg                      <= STB_LAST;
            state_reg                    <= S_RD_STB;
          end
        end
        S_RD_STB:
        begin
          if (tmr_reg == '0)
          begin
            o_rd_n    <= 1'b1;
            o_cs_n    <= 1'b1;
            left_reg  <= left_reg - 10'h001;
            tmr_reg   <= REC_LAST;
            state_reg <= S_GAP;
          end
          else
            tmr_reg <= tmr_reg - 4'h1;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // Read data toward the user; the strobe is long enough for the synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 16'h0000;
      o_rd_last  <= 1'b0;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      o_rd_last  <= 1'b0;
      if (state_reg == S_RD_STB && tmr_reg == '0)
      begin
        o_rd_valid <= 1'b1;
        o_rd_last  <= (left_reg == 10'h001);
        o_rd_data  <= din_sync_reg;
        // Byte registers and an odd final byte leave the upper half undefined
        if (kind_reg == K_RD_WORD || (left_reg == 10'h001 && odd_reg))
          o_rd_data <= {8'h00, din_sync_reg[7:0]};
      end
    end
  end
endmodule
